// ### stacked_cmd_handler.sv
// multi-block read/write request executor with more-time replies
// assumes: payload bytes arrive after cmd_start, register map answers on clk
`timescale 1ns/1ps
`include "stacked_cmd_defs.svh"
//
// Behaviour
// - slow command sends more-time reply with tag
// - more-time replies may repeat back to back
// - read entry count comes from packet size
// - read entry is address, reserved, length; 12 bytes
// - read data packed back to back
// - short read sets failure status
// - no read entries after a failure
// - read reply carries only good data
// - addresses and lengths are byte granular
// - write entries walked until size used up
// - write entry header then data bytes
// - write payload size from common header length
// - writes in order, skip rest on error
// - written length reported for every entry

module stacked_cmd_handler
  import stacked_cmd_pkg::*;
#(
  parameter int unsigned RESP_CYCLES = `MAX_RESP_MS * `MS_CYCLES,
  parameter int unsigned MS_CYCLES   = `MS_CYCLES,
  parameter int          FIFO_DEPTH  = 16
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        cmd_start,
  input  wire logic [15:0] cmd_id,
  input  wire logic [15:0] cmd_tag,
  input  wire logic [15:0] cmd_len,
  input  wire logic        in_valid,
  input  wire logic [7:0]  in_data,
  output logic             in_ready,
  output logic             mem_req,
  output logic             mem_we,
  output logic [63:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic        mem_err,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic [15:0] more_time_ms,
  output logic             pend_valid,
  output logic [15:0]      pend_tag,
  output logic [31:0]      pend_payload,
  output logic             out_valid,
  output logic [7:0]       out_data,
  input  wire logic        out_ready,
  output logic             reply_done,
  output logic [15:0]      reply_id,
  output logic [15:0]      reply_tag,
  output logic [15:0]      reply_status,
  output logic [15:0]      reply_len
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  handler_state_t state_reg;
  handler_state_t state_next;
  logic        write_reg;
  logic        skip_reg;
  logic [15:0] id_reg;
  logic [15:0] tag_reg;
  logic [15:0] rem_reg;
  logic [3:0]  hcnt_reg;
  logic [63:0] addr_reg;
  logic [15:0] elen_reg;
  logic [15:0] done_reg;
  logic [15:0] wcnt_reg;
  logic [1:0]  widx_reg;
  logic [7:0]  wdata_reg;
  logic [15:0] status_reg;
  logic [15:0] rlen_reg;
  logic [31:0] busy_cnt_reg;
  logic [31:0] limit_reg;
  logic        pend_reg;
  logic [15:0] pend_ms_reg;

  byte_stream_if #(.WIDTH(8)) push_if ();
  byte_stream_if #(.WIDTH(8)) pop_if ();

  reply_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk   (clk),
    .rst_b (rst_b),
    .push  (push_if.drain),
    .pop   (pop_if.fill)
  );

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire is_read     = (cmd_id == `ID_MULTI_READ_REQ);
  wire is_write    = (cmd_id == `ID_MULTI_WRITE_REQ);
  wire entry_full  = (done_reg == elen_reg);
  wire last_byte   = (rem_reg == 16'h0001);
  wire take        = in_valid && in_ready;
  wire hdr_last    = (hcnt_reg == `ENTRY_HDR_LAST);
  wire rd_good     = (state_reg == ST_RD) && mem_ack && !mem_err;
  wire rd_bad      = (state_reg == ST_RD) && mem_ack && mem_err;
  wire wr_good     = (state_reg == ST_WMEM) && mem_ack && !mem_err;
  wire wr_bad      = (state_reg == ST_WMEM) && mem_ack && mem_err;
  wire wlen_push   = (state_reg == ST_WLEN) && push_if.ready;
  wire busy        = (state_reg != ST_IDLE);
  wire pend_fire   = busy && (busy_cnt_reg >= limit_reg - 32'd1);
  wire [31:0] half_ms_cycles = (32'(pend_ms_reg) * MS_CYCLES) >> 1;

  // length field of the write reply: two zero bytes then count, low byte first
  wire [7:0] wlen_byte = (widx_reg <= `WLEN_RSV_LAST) ? 8'h00 :
                         (widx_reg == `WLEN_LO_OFS) ? wcnt_reg[7:0] : wcnt_reg[15:8];

  assign in_ready = (state_reg == ST_HDR) || (state_reg == ST_DRAIN) ||
                    ((state_reg == ST_WLOAD) && !entry_full && rem_reg != 16'h0000);
  // a read is requested only with room for its byte, so its push never stalls
  assign mem_req  = ((state_reg == ST_RD) && !entry_full && push_if.ready) ||
                    ((state_reg == ST_WMEM) && !skip_reg);
  assign mem_we   = (state_reg == ST_WMEM);
  assign mem_addr = addr_reg;
  assign mem_wdata = wdata_reg;

  assign push_if.valid = rd_good || (state_reg == ST_WLEN);
  assign push_if.data  = (state_reg == ST_WLEN) ? wlen_byte : mem_rdata;
  assign out_valid     = pop_if.valid;
  assign out_data      = pop_if.data;
  assign pop_if.ready  = out_ready;

  assign reply_done   = (state_reg == ST_DONE);
  assign reply_id     = id_reg;
  assign reply_tag    = tag_reg;
  assign reply_status = status_reg;
  assign reply_len    = rlen_reg;
  assign pend_valid   = pend_reg;
  assign pend_tag     = tag_reg;
  assign pend_payload = {pend_ms_reg, 16'h0000};

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cmd_start) begin
          if (!is_read && !is_write) state_next = (cmd_len == 16'h0000) ? ST_DONE : ST_DRAIN;
          else state_next = (cmd_len == 16'h0000) ? ST_DONE : ST_HDR;
        end
      end
      ST_HDR: begin
        if (take && last_byte && !hdr_last) state_next = ST_DONE;
        else if (take && hdr_last) state_next = write_reg ? ST_WLOAD : ST_RD;
      end
      ST_RD: begin
        if (rd_bad) state_next = (rem_reg == 16'h0000) ? ST_DONE : ST_DRAIN;
        else if (entry_full) state_next = (rem_reg == 16'h0000) ? ST_DONE : ST_HDR;
      end
      ST_WLOAD: begin
        if (entry_full || rem_reg == 16'h0000) state_next = ST_WLEN;
        else if (take && !skip_reg) state_next = ST_WMEM;
      end
      ST_WMEM: begin
        if (skip_reg || mem_ack) state_next = ST_WLOAD;
      end
      ST_WLEN: begin
        if (wlen_push && widx_reg == `WLEN_HI_OFS) begin
          state_next = (rem_reg == 16'h0000) ? ST_DONE : ST_HDR;
        end
      end
      ST_DRAIN: begin
        if (rem_reg == 16'h0000 || (take && last_byte)) state_next = ST_DONE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) state_reg <= ST_IDLE;
    else state_reg <= state_next;
  end

  // command context and payload accounting
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      write_reg <= 1'b0;
      id_reg    <= 16'h0000;
      tag_reg   <= 16'h0000;
      rem_reg   <= 16'h0000;
    end else if (state_reg == ST_IDLE && cmd_start) begin
      write_reg <= is_write;
      id_reg    <= cmd_id | 16'h0001;
      tag_reg   <= cmd_tag;
      rem_reg   <= cmd_len;
    end else if (take) begin
      rem_reg   <= rem_reg - 16'h0001;
    end
  end

  // entry header capture: address low byte first, then reserved, then length
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hcnt_reg <= 4'h0;
      elen_reg <= 16'h0000;
    end else if (state_reg == ST_IDLE) begin
      hcnt_reg <= 4'h0;
    end else if (state_reg == ST_HDR && take) begin
      hcnt_reg <= hdr_last ? 4'h0 : hcnt_reg + 4'h1;
      if (hcnt_reg == `ENTRY_LEN_LO_OFS) elen_reg[7:0] <= in_data;
      if (hcnt_reg == `ENTRY_LEN_HI_OFS) elen_reg[15:8] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_reg <= 64'h0000_0000_0000_0000;
    end else if (state_reg == ST_HDR && take && hcnt_reg <= `ENTRY_ADDR_LAST) begin
      addr_reg <= {in_data, addr_reg[63:8]};
    end else if (rd_good || wr_good) begin
      addr_reg <= addr_reg + 64'h1;
    end
  end

  // progress within one entry
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_reg  <= 16'h0000;
      wcnt_reg  <= 16'h0000;
      widx_reg  <= 2'b00;
      wdata_reg <= 8'h00;
    end else if (state_reg == ST_HDR) begin
      done_reg  <= 16'h0000;
      wcnt_reg  <= 16'h0000;
      widx_reg  <= 2'b00;
    end else begin
      if (rd_good) done_reg <= done_reg + 16'h0001;
      if (state_reg == ST_WLOAD && take) begin
        done_reg  <= done_reg + 16'h0001;
        wdata_reg <= in_data;
      end
      if (wr_good) wcnt_reg <= wcnt_reg + 16'h0001;
      if (wlen_push) widx_reg <= widx_reg + 2'b01;
    end
  end

  // outcome: an access error stops further accesses; a later cut entry header still overwrites it with bad length
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= `STATUS_OK;
      skip_reg   <= 1'b0;
      rlen_reg   <= 16'h0000;
    end else if (state_reg == ST_IDLE) begin
      if (cmd_start) begin
        status_reg <= (is_read || is_write) ? `STATUS_OK : `STATUS_BAD_CMD;
        skip_reg   <= 1'b0;
        rlen_reg   <= 16'h0000;
      end
    end else begin
      if (push_if.valid && push_if.ready) rlen_reg <= rlen_reg + 16'h0001;
      if (rd_bad || wr_bad) begin
        status_reg <= `STATUS_ACCESS_ERR;
        skip_reg   <= 1'b1;
      end else if (state_reg == ST_HDR && take && last_byte && !hdr_last) begin
        status_reg <= `STATUS_BAD_LEN;
      end else if (state_reg == ST_WLOAD && !entry_full && rem_reg == 16'h0000 &&
                   status_reg == `STATUS_OK) begin
        status_reg <= `STATUS_BAD_LEN;
        skip_reg   <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // more-time replies
  // ---------------------------------------------------------------
  // fire at half of the timeout the host currently holds, leaving margin for
  // the reply to cross the link before that timeout runs out
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt_reg <= 32'h0000_0000;
      limit_reg    <= 32'h0000_0001;
      pend_reg     <= 1'b0;
      pend_ms_reg  <= 16'h0000;
    end else begin
      pend_reg <= pend_fire;
      if (!busy) begin
        busy_cnt_reg <= 32'h0000_0000;
        limit_reg    <= (RESP_CYCLES > 32'd1) ? (RESP_CYCLES >> 1) : 32'd1;
        pend_ms_reg  <= more_time_ms;
      end else if (pend_fire) begin
        busy_cnt_reg <= 32'h0000_0000;
        // a floor of two keeps back to back replies at least two cycles apart
        limit_reg    <= (half_ms_cycles < 32'd2) ? 32'd2 : half_ms_cycles;
      end else begin
        busy_cnt_reg <= busy_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence hdr_done_s;
    state_reg == ST_HDR && take && hdr_last && !last_byte;
  endsequence

  sequence rd_fail_s;
    rd_bad;
  endsequence

  sequence wlen_end_s;
    wlen_push && widx_reg == `WLEN_HI_OFS;
  endsequence

  pend_busy_a: assert property (pend_valid |-> $past(busy) && pend_tag == tag_reg)
    else $error("more-time reply outside a command");
  pend_rsv_a: assert property (pend_valid |-> pend_payload[15:0] == 16'h0000)
    else $error("more-time reserved field not zero");
  pend_space_a: assert property (pend_valid |=> !pend_valid)
    else $error("more-time replies closer than two cycles");
  hdr_exit_a: assert property (hdr_done_s |=> state_reg inside {ST_RD, ST_WLOAD})
    else $error("entry header did not end after twelve bytes");
  rd_stop_a: assert property (rd_fail_s |=> !mem_req [*4])
    else $error("read issued after a failed entry");
  rd_status_a: assert property (rd_fail_s |=> status_reg == `STATUS_ACCESS_ERR)
    else $error("failed read left status clear");
  rd_fill_a: assert property (push_if.valid && state_reg == ST_RD |-> mem_ack && !mem_err)
    else $error("filler byte pushed into read reply");
  len_load_a: assert property (state_reg == ST_IDLE && cmd_start |=> rem_reg == $past(cmd_len))
    else $error("payload size not taken from header length");
  wr_skip_a: assert property (wr_bad |=> skip_reg && !mem_req [*3])
    else $error("write executed after an error");
  wlen_all_a: assert property (wlen_end_s |=> state_reg != ST_WLEN && rlen_reg == $past(rlen_reg) + 16'h0001)
    else $error("written length field incomplete");
  wlen_rsv_a: assert property (wlen_push && widx_reg <= `WLEN_RSV_LAST |-> push_if.data == 8'h00)
    else $error("reserved bytes of written length not zero");
  addr_step_a: assert property (rd_good || wr_good |=> mem_addr == $past(mem_addr) + 64'h1)
    else $error("address did not step by one byte");
  rd_pack_a: assert property (rd_good |=> rlen_reg == $past(rlen_reg) + 16'h0001)
    else $error("read byte not packed into reply");
  walk_end_a: assert property (state_reg == ST_WLEN && rem_reg == 16'h0000 ##0 wlen_end_s |=> reply_done)
    else $error("write walk did not end at packet size");

endmodule

// ### stacked_cmd_defs.svh
// constants used by the stacked command handler; its reply buffer uses none of them
// assumes: included by bare name from every file that needs a number
`ifndef STACKED_CMD_DEFS_SVH
`define STACKED_CMD_DEFS_SVH

// ---------------------------------------------------------------
// command and reply identifiers
// ---------------------------------------------------------------
`define ID_PENDING_REPLY    16'h0805
`define ID_MULTI_READ_REQ   16'h0806
`define ID_MULTI_READ_REP   16'h0807
`define ID_MULTI_WRITE_REQ  16'h0808
`define ID_MULTI_WRITE_REP  16'h0809

// ---------------------------------------------------------------
// entry layout in bytes from the entry start, then byte offsets in the written-length field
// ---------------------------------------------------------------
`define ENTRY_ADDR_LAST     4'd7
`define ENTRY_LEN_LO_OFS    4'd10
`define ENTRY_LEN_HI_OFS    4'd11
`define ENTRY_HDR_LAST      4'd11
`define WLEN_RSV_LAST       2'd1
`define WLEN_LO_OFS         2'd2
`define WLEN_HI_OFS         2'd3

// ---------------------------------------------------------------
// reply status codes
// ---------------------------------------------------------------
`define STATUS_OK           16'h0000
`define STATUS_BAD_CMD      16'h0001
`define STATUS_BAD_LEN      16'h0002
`define STATUS_ACCESS_ERR   16'h0003

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS       100
`define NS_PER_MS           1000000
`define MS_CYCLES           (`NS_PER_MS / `CLK_PERIOD_NS)
`define MAX_RESP_MS         100

`endif

// ### stacked_cmd_pkg.sv
// types of the stacked command handler
// assumes: compiled before every module of the block
package stacked_cmd_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_HDR   = 3'b001,
    ST_RD    = 3'b010,
    ST_WLOAD = 3'b011,
    ST_WMEM  = 3'b100,
    ST_WLEN  = 3'b101,
    ST_DRAIN = 3'b110,
    ST_DONE  = 3'b111
  } handler_state_t;

endpackage

// ### byte_stream_if.sv
// valid/ready byte stream joining the handler to its reply buffer
// assumes: one clock domain, transfer when valid and ready are both high
`timescale 1ns/1ps

interface byte_stream_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport fill  (output valid, output data, input ready);
  modport drain (input valid, input data, output ready);
endinterface

// ### reply_fifo.sv
// flop based fifo for reply payload bytes
// assumes: push side honours ready, pop side may stall at will
`timescale 1ns/1ps

module reply_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic    clk,
  input  wire logic    rst_b,
  byte_stream_if.drain push,
  byte_stream_if.fill  pop
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;

  wire full   = (count_reg == (AW+1)'(DEPTH));
  wire empty  = (count_reg == '0);
  wire do_wr  = push.valid && !full;
  wire do_rd  = pop.ready && !empty;
  wire wr_end = (wr_ptr_reg == AW'(DEPTH - 1));
  wire rd_end = (rd_ptr_reg == AW'(DEPTH - 1));

  assign push.ready = !full;
  assign pop.valid  = !empty;
  assign pop.data   = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_reg[wr_ptr_reg] <= push.data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (do_wr) wr_ptr_reg <= wr_end ? '0 : wr_ptr_reg + 1'b1;
      if (do_rd) rd_ptr_reg <= rd_end ? '0 : rd_ptr_reg + 1'b1;
      if (do_wr && !do_rd) count_reg <= count_reg + 1'b1;
      else if (do_rd && !do_wr) count_reg <= count_reg - 1'b1;
    end
  end
endmodule

// ### reg_map_model.sv
// register map model answering the handler's memory port
// assumes: one clock, request held until acknowledged, one access at a time
`timescale 1ns/1ps

module reg_map_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [63:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic [3:0]  delay,
  input  wire logic [63:0] err_addr,
  output logic             mem_ack,
  output logic             mem_err,
  output logic [7:0]       mem_rdata
);
  logic [7:0] wmem [logic [63:0]];
  int         n_acc;
  int         n_wr;
  int         wait_cnt;

  // ---------------------------------------------------------------
  // access engine
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack   <= 1'b0;
      mem_err   <= 1'b0;
      mem_rdata <= 8'h00;
      wait_cnt  <= 0;
    end else if (mem_ack) begin
      mem_ack   <= 1'b0;
      mem_err   <= 1'b0;
      // a released data bus does not keep showing the old byte
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && wait_cnt < int'(delay)) begin
      wait_cnt <= wait_cnt + 1;
    end else if (mem_req) begin
      wait_cnt  <= 0;
      mem_ack   <= 1'b1;
      mem_err   <= (mem_addr == err_addr);
      mem_rdata <= mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3c;
      n_acc = n_acc + 1;
      if (mem_we && mem_addr != err_addr) begin
        wmem[mem_addr] = mem_wdata;
        n_wr = n_wr + 1;
      end
    end
  end
endmodule

// ### stacked_memory_command_handler_tb.sv
// self-checking bench of the stacked command handler
// assumes: reg_map_model on the memory port, bench plays the host side
`timescale 1ns/1ps

module stacked_memory_command_handler_tb;
  logic        clk, rst_b, cmd_start, in_valid, in_ready, mem_req, mem_we, mem_ack;
  logic        mem_err, pend_valid, out_valid, out_ready, reply_done, stall;
  logic [15:0] cmd_id, cmd_tag, cmd_len, more_time_ms, pend_tag, cur_tag;
  logic [15:0] reply_id, reply_tag, reply_status, reply_len;
  logic [7:0]  in_data, mem_wdata, mem_rdata, out_data;
  logic [63:0] mem_addr, err_addr;
  logic [31:0] pend_payload, seed;
  logic [3:0]  delay;
  logic [7:0]  pay[$], exp[$], got[$];
  logic [7:0]  wexp [logic [63:0]];
  int          fails, n_tests, cycles, cyc, last, lim, n_pend;

  stacked_cmd_handler #(.RESP_CYCLES(40), .MS_CYCLES(8)) u_stacked_cmd_handler (
    .clk(clk), .rst_b(rst_b), .cmd_start(cmd_start), .cmd_id(cmd_id), .cmd_tag(cmd_tag),
    .cmd_len(cmd_len), .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata),
    .more_time_ms(more_time_ms), .pend_valid(pend_valid), .pend_tag(pend_tag),
    .pend_payload(pend_payload), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready), .reply_done(reply_done), .reply_id(reply_id),
    .reply_tag(reply_tag), .reply_status(reply_status), .reply_len(reply_len));

  reg_map_model u_reg_map_model (
    .clk(clk), .rst_b(rst_b), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .delay(delay), .err_addr(err_addr), .mem_ack(mem_ack),
    .mem_err(mem_err), .mem_rdata(mem_rdata));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic [7:0] rd_val(input logic [63:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      fails++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // address low byte first, reserved zero, length low byte first
  task automatic add_entry(input logic [63:0] a, input logic [15:0] l);
    for (int i = 0; i < 8; i++) pay.push_back(a[8*i +: 8]);
    pay.push_back(8'h00);
    pay.push_back(8'h00);
    pay.push_back(l[7:0]);
    pay.push_back(l[15:8]);
  endtask

  task automatic add_wentry(input logic [63:0] a, input logic [15:0] l);
    logic [7:0] d;
    add_entry(a, l);
    for (int i = 0; i < int'(l); i++) begin
      d = lfsr();
      pay.push_back(d);
      wexp[a + 64'(i)] = d;
    end
  endtask

  task automatic run(input logic [15:0] id);
    int k;
    got = {};
    cur_tag = lfsr();
    cmd_start = 1'b1;
    cmd_id = id;
    cmd_tag = cur_tag;
    cmd_len = 16'(pay.size());
    last = cyc;
    lim = 40;
    @(posedge clk);
    #1;
    cmd_start = 1'b0;
    foreach (pay[i]) begin
      in_valid = 1'b1;
      in_data = pay[i];
      for (k = 0; k < 100; k++) begin
        @(negedge clk);
        if (in_ready === 1'b1) break;
      end
      @(posedge clk);
      #1;
    end
    in_valid = 1'b0;
    in_data = ~in_data;
    for (k = 0; k < 3000 && reply_done !== 1'b1; k++) @(negedge clk);
    chk(k < 3000, "no reply");
    for (k = 0; k < 500 && out_valid === 1'b1; k++) @(negedge clk);
    @(posedge clk);
    #1;
  endtask

  task automatic chk_reply(input logic [15:0] id, input logic [15:0] st);
    chk(reply_id === (id | 16'h0001), "reply id");
    chk(reply_tag === cur_tag, "reply tag");
    chk(reply_status === st, "reply status");
    chk(reply_len === 16'(exp.size()), "reply length");
    chk(got.size() == exp.size(), "payload size");
    foreach (exp[i]) if (i < got.size()) chk(got[i] === exp[i], "payload byte");
  endtask

  // ---------------------------------------------------------------
  // clock, far-side stall, monitors, watchdog
  // ---------------------------------------------------------------
  always #50 clk = ~clk;

  always @(posedge clk) begin
    #1;
    out_ready = !stall && lfsr() % 4 != 0;
  end

  always @(negedge clk) begin
    cyc++;
    if (out_valid === 1'b1 && out_ready) got.push_back(out_data);
    if (pend_valid === 1'b1) begin
      chk(pend_tag === cur_tag, "pending tag");
      chk(pend_payload === {more_time_ms, 16'h0000}, "pending payload");
      chk(cyc - last <= lim, "pending late");
      n_pend++;
      last = cyc;
      lim = int'(more_time_ms) * 8;
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("BAD %0t timeout", $time);
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    logic [63:0] a0, a1;
    int          acc0, p0, n, l;
    seed = 32'h6970;
    {clk, rst_b, cmd_start, in_valid, out_ready} = '0;
    {cmd_id, cmd_tag, cmd_len, in_data, delay} = '0;
    err_addr = '1;
    more_time_ms = 16'h0002;
    stall = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rst_b = 1'b1;
    // full fifo holds reads back while more-time replies keep coming
    pay = {};
    a0 = {lfsr(), lfsr()};
    add_entry(a0, 16'd20);
    exp = {};
    for (int i = 0; i < 20; i++) exp.push_back(rd_val(a0 + 64'(i)));
    acc0 = u_reg_map_model.n_acc;
    p0 = n_pend;
    fork
      run(16'h0806);
      begin
        repeat (100) @(negedge clk);
        chk(u_reg_map_model.n_acc - acc0 == 16, "fifo full not refused");
        chk(out_valid === 1'b1, "fifo not holding");
        stall = 1'b0;
      end
    join
    chk_reply(16'h0806, 16'h0000);
    chk(n_pend - p0 >= 2, "repeated pending");
    $display("done stall");
    repeat (4) begin
      pay = {};
      exp = {};
      delay = lfsr();
      more_time_ms = 16'(1 + lfsr() % 3);
      n = 1 + lfsr() % 3;
      repeat (n) begin
        a0 = {lfsr(), lfsr()};
        l = 1 + lfsr() % 5;
        add_entry(a0, 16'(l));
        for (int i = 0; i < l; i++) exp.push_back(rd_val(a0 + 64'(i)));
      end
      run(16'h0806);
      chk_reply(16'h0806, 16'h0000);
    end
    $display("done reads");
    pay = {};
    a0 = {lfsr(), lfsr()};
    a1 = {lfsr(), lfsr()};
    add_entry(a0, 16'd3);
    add_entry(a1, 16'd2);
    add_entry(a0 + 64'd100, 16'd2);
    exp = {rd_val(a0), rd_val(a0 + 64'd1), rd_val(a0 + 64'd2)};
    err_addr = a1;
    acc0 = u_reg_map_model.n_acc;
    run(16'h0806);
    chk_reply(16'h0806, 16'h0003);
    chk(u_reg_map_model.n_acc - acc0 == 4, "read after failure");
    $display("done read error");
    for (int e = 0; e < 2; e++) begin
      pay = {};
      wexp.delete();
      a0 = {lfsr(), lfsr()};
      add_wentry(a0, 16'd3);
      add_wentry(a0 + 64'h40, 16'd2);
      err_addr = e ? a0 + 64'd1 : '1;
      acc0 = u_reg_map_model.n_wr;
      run(16'h0808);
      exp = {8'h00, 8'h00, e ? 8'h01 : 8'h03, 8'h00, 8'h00, 8'h00, e ? 8'h00 : 8'h02, 8'h00};
      chk_reply(16'h0808, e ? 16'h0003 : 16'h0000);
      chk(u_reg_map_model.n_wr - acc0 == (e ? 1 : 5), "write count");
      if (!e)
        foreach (wexp[k]) chk(u_reg_map_model.wmem[k] === wexp[k], "written byte");
    end
    $display("done writes");
    err_addr = '1;
    pay = {8'h11, 8'h22};
    exp = {};
    run(16'h0810);
    chk_reply(16'h0810, 16'h0001);
    pay = {8'h01, 8'h02, 8'h03, 8'h04, 8'h05};
    run(16'h0806);
    chk_reply(16'h0806, 16'h0002);
    $display("done refusals");
    // empty payload ends at once, write data cut short by the payload end
    pay = {};
    exp = {};
    run(16'h0806);
    chk_reply(16'h0806, 16'h0000);
    pay = {};
    wexp.delete();
    a0 = {lfsr(), lfsr()};
    add_wentry(a0, 16'd3);
    void'(pay.pop_back());
    void'(pay.pop_back());
    acc0 = u_reg_map_model.n_wr;
    run(16'h0808);
    exp = {8'h00, 8'h00, 8'h01, 8'h00};
    chk_reply(16'h0808, 16'h0002);
    chk(u_reg_map_model.n_wr - acc0 == 1, "cut write count");
    $display("done corners");
    finish_test();
  end
endmodule
